// >>> hdl/soch_top.sv
// Command interpreter holding the scope option state
`timescale 1ns/1ps
//Contract
//[R01] Video entry: level 100, line marker 10, NTSC; mode reads video.
//[R02] Video negative level gives inverted video at the magnitude.
//[R03] Pulse entry: width 100 ns, period 1 us, 2.5 V range.
//[R04] Overload entry: DC range at 5 V; range picks DC or AC.
//[R05] Mode query returns one of ten mode names.
//[R06] Trigger output off or at divide by one, ten or hundred.
//[R07] Trigger query returns the stored divider setting.
//[R08] Impedance selects 50 ohm or 1 megohm; query returns it.
//[R09] Range only in pulse, impedance, overload; six pulse codes.
//[R10] Impedance mode range: res 50 ohm, res 1 megohm, capacitance.
//[R11] Edge mode diode drive set by nonzero, cleared by zero; reads 1/0.
//[R12] Marker waveform: sine, spike, square, narrow square.
//[R13] Video format NTSC, PAL, PAL-M, SECAM; query returns it.
//[R14] Video line marker stored and read back.
//[R15] Trip query gives seconds to trip, zero if none or not overload.
//[R16] Time limit 1 to 60 s; trip or expiry returns to standby.
//[R17] Time limit query returns programmed seconds.
//[R18] Default limit settable 1 to 60 s and readable.
//[R19] Zeroing on takes present capacitance as offset.
//[R20] Trigger in impedance mode measures; ohm, farad or none tag.
//[R21] Value query returns last result without measuring.
//[R22] Mode, trigger, impedance commands busy until settled.
//[R23] Settings hold until changed or mode defaults load.
module soch_top #(
   parameter int unsigned SEC_CYCLES    = soch_pkg::SEC_CYC,
   parameter int unsigned SETTLE_CYCLES = soch_pkg::SETTLE_CYC
) (
   // Clock and reset
   input  wire logic                   CLK_SYS,
   input  wire logic                   RESET,
   // Command port
   input  wire logic                   CMD_VALID,
   input  wire soch_pkg::soch_op_type  CMD_OP,
   input  wire logic signed [15:0]     CMD_ARG,
   output logic                        CMD_READY,
   output logic                        CMD_ERROR,
   // Answers
   output logic                        RSP_VALID,
   output soch_pkg::soch_rsp_type      RSP,
   // Settings and output state
   output soch_pkg::soch_cfg_type      SETTINGS,
   output logic                        OPERATE,
   // Protection trip pin
   input  wire logic                   PROT_TRIP,
   // Measurement engine
   output logic                        MEAS_START,
   input  wire logic                   MEAS_DONE,
   input  wire soch_pkg::soch_meas_type MEAS_RESULT
);
   if (SEC_CYCLES < 2 || SETTLE_CYCLES < 1
       || SETTLE_CYCLES > 255) begin : g_bad
      $error("soch_top: unusable cycle parameters");
   end

   soch_pkg::soch_cfg_type cfg_q;
   soch_pkg::soch_rsp_type rsp_q;
   logic [7:0]         settle_q;
   logic               rdy_q, err_q, rv_q, mstart_q, mwait_q, oper_q;
   logic [31:0]        div_q;
   logic [5:0]         elapsed_q, trip_s_q, tlim_q, tlimd_q;
   logic               trip_m_q, trip_y_q, trip_p_q;
   logic signed [31:0] val_q, offs_q;
   soch_pkg::soch_tag_type vtag_q;

   wire take   = CMD_VALID && rdy_q;
   wire is_ovl = cfg_q.mode == soch_pkg::M_OVERLOAD;
   wire is_imp = cfg_q.mode == soch_pkg::M_IMPED;
   wire arg_nz = CMD_ARG != 16'sh0000;
   wire trip_e = trip_y_q && !trip_p_q;
   wire tick   = oper_q && is_ovl && div_q == 32'(SEC_CYCLES - 1);
   wire lim_ok = CMD_ARG >= 16'(soch_pkg::LIM_MIN)
                 && CMD_ARG <= 16'(soch_pkg::LIM_MAX);

   // Range code legal for the present mode
   function automatic logic rng_ok(input soch_pkg::soch_mode_type m,
                                   input logic signed [15:0] a);
      logic [2:0] lim;
      lim = 3'h0;
      unique case (m)
         soch_pkg::M_PULSE:    lim = soch_pkg::PRNG_MAX;
         soch_pkg::M_IMPED:    lim = soch_pkg::ZRNG_MAX;
         soch_pkg::M_OVERLOAD: lim = soch_pkg::ORNG_MAX;
         default:              return 1'b0;
      endcase
      return a >= 16'sh0000 && a <= 16'(lim);
   endfunction

   // Pin synchroniser, edge taken after second stage
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         trip_m_q <= 1'b0;
         trip_y_q <= 1'b0;
         trip_p_q <= 1'b0;
      end else begin
         trip_m_q <= PROT_TRIP;
         trip_y_q <= trip_m_q;
         trip_p_q <= trip_y_q;
      end
   end

   // Slow commands hold the port until settled
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         settle_q <= 8'h00;
         rdy_q    <= 1'b0;
      end else if (take && (CMD_OP == soch_pkg::OP_MODE
                 || CMD_OP == soch_pkg::OP_TRG
                 || CMD_OP == soch_pkg::OP_IMP)) begin
         settle_q <= 8'(SETTLE_CYCLES);      // see [R22]
         rdy_q    <= 1'b0;
      end else if (take && CMD_OP == soch_pkg::OP_MEAS_TRG && is_imp) begin
         rdy_q    <= 1'b0;
      end else if (settle_q != 8'h00) begin
         settle_q <= settle_q - 8'h01;
         rdy_q    <= settle_q == 8'h01 && !mwait_q;
      end else begin
         rdy_q    <= !mwait_q || MEAS_DONE;
      end
   end

   // Stored settings, mode entry loads defaults
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         cfg_q <= '0;
      end else if (take) begin
         unique case (CMD_OP)
            soch_pkg::OP_MODE: begin
               cfg_q.mode <= soch_pkg::soch_mode_type'(CMD_ARG[3:0]);
               unique case (CMD_ARG[3:0])
                  4'(soch_pkg::M_VIDEO): begin   // see [R01]
                     cfg_q.level               <= soch_pkg::VID_LEVEL;
                     cfg_q.invert              <= 1'b0;
                     cfg_q.video_line_marker   <= soch_pkg::VID_LINE;
                     cfg_q.video_format_select <= soch_pkg::VF_NTSC;
                  end
                  4'(soch_pkg::M_PULSE): begin   // see [R03]
                     cfg_q.pulse_width  <= soch_pkg::PLS_WIDTH;
                     cfg_q.pulse_period <= soch_pkg::PLS_PERIOD;
                     cfg_q.prng         <= soch_pkg::PR_2V5;
                  end
                  4'(soch_pkg::M_OVERLOAD): begin   // see [R04]
                     cfg_q.orng  <= soch_pkg::OR_DC;
                     cfg_q.level <= soch_pkg::OVL_LEVEL;
                  end
                  default: ;
               endcase
            end
            soch_pkg::OP_TRG:                          // see [R06]
               cfg_q.trg_div <= soch_pkg::soch_trg_type'(CMD_ARG[1:0]);
            soch_pkg::OP_IMP:                          // see [R08]
               cfg_q.imp <= soch_pkg::soch_imp_type'(CMD_ARG[0]);
            soch_pkg::OP_RANGE:
               if (rng_ok(cfg_q.mode, CMD_ARG)) begin   // see [R09]
                  unique case (cfg_q.mode)
                     soch_pkg::M_PULSE:
                        cfg_q.prng <= soch_pkg::soch_prng_type'(CMD_ARG[2:0]);
                     soch_pkg::M_IMPED:                     // see [R10]
                        cfg_q.zrng <= soch_pkg::soch_zrng_type'(CMD_ARG[1:0]);
                     default:                               // see [R04]
                        cfg_q.orng <= soch_pkg::soch_orng_type'(CMD_ARG[0]);
                  endcase
               end
            soch_pkg::OP_OUT:
               if (cfg_q.mode == soch_pkg::M_VIDEO && CMD_ARG[15]) begin
                  cfg_q.level  <= -CMD_ARG;          // see [R02]
                  cfg_q.invert <= 1'b1;
               end else if (!is_imp) begin
                  cfg_q.level  <= CMD_ARG;
                  cfg_q.invert <= 1'b0;
               end
            soch_pkg::OP_DPULSE:
               if (cfg_q.mode == soch_pkg::M_EDGE)
                  cfg_q.diode_pulse_drive <= arg_nz;   // see [R11]
            soch_pkg::OP_WAVE:                           // see [R12]
               cfg_q.marker_waveform_select <=
                  soch_pkg::soch_wave_type'(CMD_ARG[1:0]);
            soch_pkg::OP_VFMT:                           // see [R13]
               cfg_q.video_format_select <=
                  soch_pkg::soch_vfmt_type'(CMD_ARG[1:0]);
            soch_pkg::OP_VMARK:
               cfg_q.video_line_marker <= CMD_ARG;    // see [R14]
            soch_pkg::OP_ZERO:
               cfg_q.capacitance_zeroing <= arg_nz;
            default: ;                                // see [R23]
         endcase
      end
   end

   // Time limits, stored only when in range
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         tlim_q  <= soch_pkg::LIM_RST;
         tlimd_q <= soch_pkg::LIM_RST;
      end else if (take && lim_ok && CMD_OP == soch_pkg::OP_TLIM) begin
         tlim_q  <= CMD_ARG[5:0];                     // see [R16]
      end else if (take && lim_ok && CMD_OP == soch_pkg::OP_TLIMD) begin
         tlimd_q <= CMD_ARG[5:0];                     // see [R18]
      end else if (take && CMD_OP == soch_pkg::OP_MODE
                   && CMD_ARG[3:0] == 4'(soch_pkg::M_OVERLOAD)) begin
         tlim_q  <= tlimd_q;
      end
   end

   // Operate timer: in overload mode trip or expiry falls back to standby
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         oper_q    <= 1'b0;
         div_q     <= '0;
         elapsed_q <= 6'h00;
         trip_s_q  <= 6'h00;
      end else if (take && CMD_OP == soch_pkg::OP_OPER) begin
         oper_q    <= 1'b1;
         div_q     <= '0;
         elapsed_q <= 6'h00;
         trip_s_q  <= 6'h00;
      end else if ((take && (CMD_OP == soch_pkg::OP_STBY
                   || CMD_OP == soch_pkg::OP_MODE)) || !oper_q) begin
         oper_q    <= 1'b0;
         div_q     <= '0;
      end else if (is_ovl && trip_e) begin
         oper_q    <= 1'b0;                           // see [R16]
         trip_s_q  <= elapsed_q + 6'h01;              // see [R15]
      end else if (tick) begin
         div_q     <= '0;
         elapsed_q <= elapsed_q + 6'h01;
         if (elapsed_q + 6'h01 >= tlim_q)
            oper_q <= 1'b0;                           // see [R16]
      end else if (is_ovl) begin
         div_q     <= div_q + 32'h1;
      end
   end

   // Measurement start and stored result
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         mstart_q <= 1'b0;
         mwait_q  <= 1'b0;
         val_q    <= '0;
         vtag_q   <= soch_pkg::TAG_NONE;
         offs_q   <= '0;
      end else begin
         mstart_q <= take && CMD_OP == soch_pkg::OP_MEAS_TRG && is_imp;
         if (take && CMD_OP == soch_pkg::OP_MEAS_TRG && is_imp)
            mwait_q <= 1'b1;                          // see [R20]
         else if (MEAS_DONE)
            mwait_q <= 1'b0;
         if (MEAS_DONE) begin
            val_q  <= MEAS_RESULT.is_cap
                      ? MEAS_RESULT.value - offs_q : MEAS_RESULT.value;
            vtag_q <= MEAS_RESULT.is_cap
                      ? soch_pkg::TAG_FARAD : soch_pkg::TAG_OHM;
         end
         if (take && CMD_OP == soch_pkg::OP_ZERO)    // see [R19]
            offs_q <= arg_nz && vtag_q == soch_pkg::TAG_FARAD
                      ? val_q + offs_q : '0;
      end
   end

   // Answers and refusals
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rv_q  <= 1'b0;
         err_q <= 1'b0;
         rsp_q <= '{tag: soch_pkg::TAG_NONE, value: '0};
      end else begin
         rv_q  <= 1'b0;
         err_q <= 1'b0;
         rsp_q.tag <= soch_pkg::TAG_PLAIN;
         if (mwait_q && MEAS_DONE) begin
            rv_q  <= 1'b1;
            rsp_q.tag   <= MEAS_RESULT.is_cap
                           ? soch_pkg::TAG_FARAD : soch_pkg::TAG_OHM;
            rsp_q.value <= MEAS_RESULT.is_cap
                           ? MEAS_RESULT.value - offs_q : MEAS_RESULT.value;
         end else if (take) begin
            rv_q <= 1'b1;
            unique case (CMD_OP)
               soch_pkg::OP_MODE_Q:                   // see [R05]
                  rsp_q.value <= 32'(cfg_q.mode);
               soch_pkg::OP_TRG_Q:                    // see [R07]
                  rsp_q.value <= 32'(cfg_q.trg_div);
               soch_pkg::OP_IMP_Q: rsp_q.value <= 32'(cfg_q.imp);
               soch_pkg::OP_DPULSE_Q:
                  rsp_q.value <= 32'(cfg_q.diode_pulse_drive);
               soch_pkg::OP_WAVE_Q:
                  rsp_q.value <= 32'(cfg_q.marker_waveform_select);
               soch_pkg::OP_VFMT_Q:
                  rsp_q.value <= 32'(cfg_q.video_format_select);
               soch_pkg::OP_VMARK_Q:
                  rsp_q.value <= 32'(cfg_q.video_line_marker);
               soch_pkg::OP_TRIP_Q:                   // see [R15]
                  rsp_q.value <= is_ovl ? 32'(trip_s_q) : '0;
               soch_pkg::OP_TLIM_Q: rsp_q.value <= 32'(tlim_q); // see [R17]
               soch_pkg::OP_TLIMD_Q: rsp_q.value <= 32'(tlimd_q);
               soch_pkg::OP_VAL_Q: begin              // see [R21]
                  rsp_q.tag   <= vtag_q;
                  rsp_q.value <= val_q;
               end
               soch_pkg::OP_MEAS_TRG: begin
                  rv_q  <= 1'b0;
                  err_q <= !is_imp;
               end
               default: begin
                  rv_q  <= 1'b0;
                  err_q <= (CMD_OP == soch_pkg::OP_RANGE
                            && !rng_ok(cfg_q.mode, CMD_ARG))
                           || ((CMD_OP == soch_pkg::OP_TLIM
                            || CMD_OP == soch_pkg::OP_TLIMD) && !lim_ok);
               end
            endcase
         end
      end
   end

   assign CMD_READY  = rdy_q;
   assign CMD_ERROR  = err_q;
   assign RSP_VALID  = rv_q;
   assign RSP        = rsp_q;
   assign SETTINGS   = cfg_q;
   assign OPERATE    = oper_q;
   assign MEAS_START = mstart_q;

   video_entry_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      take && CMD_OP == soch_pkg::OP_MODE
      && CMD_ARG[3:0] == 4'(soch_pkg::M_VIDEO) |=> cfg_q.level == 16'h0064
      && cfg_q.video_line_marker == 16'h000a && !cfg_q.invert)
      else $error("video defaults not loaded"); // see [R01]
   video_invert_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      take && CMD_OP == soch_pkg::OP_OUT && CMD_ARG[15]
      && cfg_q.mode == soch_pkg::M_VIDEO |=> cfg_q.invert
      && cfg_q.level == -$past(CMD_ARG))
      else $error("inverse video wrong"); // see [R02]
   pulse_entry_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      take && CMD_OP == soch_pkg::OP_MODE
      && CMD_ARG[3:0] == 4'(soch_pkg::M_PULSE) |=> cfg_q.pulse_width
      == 16'd100 && cfg_q.pulse_period == 16'd1000
      && cfg_q.prng == soch_pkg::PR_2V5)
      else $error("pulse defaults not loaded"); // see [R03]
   range_gate_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      take && CMD_OP == soch_pkg::OP_RANGE && CMD_ARG > 16'sh0005
      |=> $stable(cfg_q.prng) && err_q)
      else $error("bad range taken"); // see [R09]
   settle_busy_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      take && CMD_OP == soch_pkg::OP_TRG |=> !rdy_q [*4])
      else $error("port ready before settle"); // see [R22]
   trip_stby_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      oper_q && is_ovl && trip_e && !take |=> !oper_q && trip_s_q != 6'h00)
      else $error("trip did not drop operate"); // see [R16]
   limit_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      take && CMD_OP == soch_pkg::OP_TLIM && CMD_ARG > 16'sh003c
      |=> $stable(tlim_q))
      else $error("limit out of range stored"); // see [R16]
   meas_answer_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      mwait_q && MEAS_DONE |=> rv_q && rsp_q.tag != soch_pkg::TAG_PLAIN)
      else $error("measurement not answered"); // see [R20]
   trip_query_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      take && CMD_OP == soch_pkg::OP_TRIP_Q && !is_ovl
      |=> rv_q && rsp_q.value == 32'sh0)
      else $error("trip query not zero"); // see [R15]
endmodule

// >>> pkg/soch_pkg.sv
// Shared types and constants of the scope option command handler
package soch_pkg;
   localparam int unsigned CLK_HZ     = 100_000_000;
   localparam int unsigned TICK_S     = 1;
   localparam int unsigned SEC_CYC    = TICK_S * CLK_HZ;
   localparam int unsigned SETTLE_CYC = 4;
   localparam logic [5:0]  LIM_MIN    = 6'h01;
   localparam logic [5:0]  LIM_MAX    = 6'h3c;
   localparam logic [5:0]  LIM_RST    = 6'h0a;
   localparam logic [15:0] VID_LEVEL  = 16'h0064;
   localparam logic [15:0] VID_LINE   = 16'h000a;
   localparam logic [15:0] PLS_WIDTH  = 16'h0064;
   localparam logic [15:0] PLS_PERIOD = 16'h03e8;
   localparam logic [15:0] OVL_LEVEL  = 16'h1388;
   localparam logic [2:0]  PRNG_MAX   = 3'h5;
   localparam logic [2:0]  ZRNG_MAX   = 3'h2;
   localparam logic [2:0]  ORNG_MAX   = 3'h1;

   typedef enum logic [3:0] {
      M_OFF, M_VOLT, M_EDGE, M_LEV_SINE, M_MARKER, M_WAVE_GEN,
      M_VIDEO, M_PULSE, M_IMPED, M_OVERLOAD
   } soch_mode_type;
   typedef enum logic [1:0] {TRG_OFF, TRG_BY1, TRG_BY10, TRG_BY100}
      soch_trg_type;
   typedef enum logic {IMP_FIFTY, IMP_MEG} soch_imp_type;
   // Pulse: 2.5 V, 1.0 V, 250 mV, 100 mV, 25 mV, 10 mV
   typedef enum logic [2:0] {PR_2V5, PR_1V0, PR_250M, PR_100M, PR_25M,
      PR_10M} soch_prng_type;
   typedef enum logic [1:0] {ZR_RES50, ZR_RES1M, ZR_CAP} soch_zrng_type;
   typedef enum logic {OR_DC, OR_AC} soch_orng_type;
   typedef enum logic [1:0] {WV_SINE, WV_SPIKE, WV_SQUARE, WV_NARROW}
      soch_wave_type;
   typedef enum logic [1:0] {VF_NTSC, VF_PAL, VF_PALM, VF_SECAM}
      soch_vfmt_type;
   typedef enum logic [1:0] {TAG_PLAIN, TAG_OHM, TAG_FARAD, TAG_NONE}
      soch_tag_type;
   typedef enum logic [4:0] {
      OP_MODE, OP_MODE_Q, OP_TRG, OP_TRG_Q, OP_IMP, OP_IMP_Q, OP_RANGE,
      OP_OUT, OP_DPULSE, OP_DPULSE_Q, OP_WAVE, OP_WAVE_Q, OP_VFMT,
      OP_VFMT_Q, OP_VMARK, OP_VMARK_Q, OP_TRIP_Q, OP_TLIM, OP_TLIM_Q,
      OP_TLIMD, OP_TLIMD_Q, OP_ZERO, OP_MEAS_TRG, OP_VAL_Q, OP_OPER,
      OP_STBY
   } soch_op_type;

   typedef struct packed {
      soch_mode_type  mode;
      soch_trg_type   trg_div;
      soch_imp_type   imp;
      soch_prng_type  prng;
      soch_zrng_type  zrng;
      soch_orng_type  orng;
      logic           diode_pulse_drive;
      soch_wave_type  marker_waveform_select;
      soch_vfmt_type  video_format_select;
      logic [15:0]    video_line_marker;
      logic [15:0]    level;
      logic           invert;
      logic [15:0]    pulse_width;
      logic [15:0]    pulse_period;
      logic           capacitance_zeroing;
   } soch_cfg_type;

   typedef struct packed {
      soch_tag_type       tag;
      logic signed [31:0] value;
   } soch_rsp_type;

   typedef struct packed {
      logic               is_cap;
      logic signed [31:0] value;
   } soch_meas_type;
endpackage

// >>> verif/soch_meas_model.sv
// Measurement engine stand-in answering start pulses after a delay
`timescale 1ns/1ps
module soch_meas_model #(
   parameter int DELAY = 5
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset,
   // Request and programmed answer
   input  wire logic                    start,
   input  wire logic                    is_cap,
   input  wire logic signed [31:0]      value,
   // Answer to the handler
   output logic                         done,
   output soch_pkg::soch_meas_type      result
);
   int cnt_q;
   // Result only valid with done; inverted otherwise so stale reads show
   always_ff @(posedge clk) begin
      done <= 1'b0;
      result <= ~result;
      if (reset) begin
         cnt_q <= 0;
         result <= '0;
      end else if (start) begin
         cnt_q <= DELAY;
      end else if (cnt_q == 1) begin
         cnt_q <= 0;
         done <= 1'b1;
         result <= {is_cap, value};
      end else if (cnt_q > 1) begin
         cnt_q <= cnt_q - 1;
      end
   end
endmodule

// >>> verif/soch_top_test.sv
// Self-checking bench of the scope option command handler
`timescale 1ns/1ps
module soch_top_test;
   localparam int SEC = 20;
   logic                     clk_sys, reset, cmd_valid, prot_trip;
   logic                     cmd_ready, cmd_error, rsp_valid, operate;
   logic                     meas_start, m_done, m_cap;
   logic signed [15:0]       cmd_arg;
   logic signed [31:0]       m_val;
   soch_pkg::soch_op_type    cmd_op;
   soch_pkg::soch_rsp_type   rsp;
   soch_pkg::soch_cfg_type   settings;
   soch_pkg::soch_meas_type  m_res;
   int                       n_errors, tests_run, n_starts, cycles;

   soch_top #(.SEC_CYCLES(SEC), .SETTLE_CYCLES(4)) dut (
      .CLK_SYS(clk_sys), .RESET(reset), .CMD_VALID(cmd_valid),
      .CMD_OP(cmd_op), .CMD_ARG(cmd_arg), .CMD_READY(cmd_ready),
      .CMD_ERROR(cmd_error), .RSP_VALID(rsp_valid), .RSP(rsp),
      .SETTINGS(settings), .OPERATE(operate), .PROT_TRIP(prot_trip),
      .MEAS_START(meas_start), .MEAS_DONE(m_done), .MEAS_RESULT(m_res));
   soch_meas_model #(.DELAY(5)) engine (.clk(clk_sys), .reset(reset),
      .start(meas_start), .is_cap(m_cap), .value(m_val), .done(m_done),
      .result(m_res));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Hang guard; the whole run needs well under 3000 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (meas_start === 1'b1) n_starts++;
      if (cycles == 8000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
         n_errors++;
      end
   endtask
   // Holds the request until a negedge shows ready, then one edge takes it
   task automatic send(input soch_pkg::soch_op_type op, input int arg);
      int n;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_arg <= 16'(arg);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (cmd_ready !== 1'b1 && n < 100);
      check("cmd_ready", 1, cmd_ready);
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
   endtask
   task automatic cmd(input soch_pkg::soch_op_type op, input int arg,
                      input logic err);
      send(op, arg);
      @(negedge clk_sys);
      check("cmd_error", err, cmd_error);
   endtask
   task automatic qry(input soch_pkg::soch_op_type op, input int e);
      send(op, 0);
      @(negedge clk_sys);
      check("rsp_valid", 1, rsp_valid);
      check("rsp", e, rsp.value);
   endtask

   task automatic t_modes();
      for (int m = 0; m < 10; m++) begin
         cmd(soch_pkg::OP_MODE, m, 1'b0);
         repeat (3) begin
            check("busy", 0, cmd_ready);
            @(negedge clk_sys);
         end
         check("busy", 0, cmd_ready);
         @(negedge clk_sys);
         check("ready", 1, cmd_ready);
         qry(soch_pkg::OP_MODE_Q, m);
      end
   endtask
   task automatic t_trigger_output_divider_imp();
      for (int t = 0; t < 4; t++) begin
         cmd(soch_pkg::OP_TRG, t, 1'b0);
         qry(soch_pkg::OP_TRG_Q, t);
      end
      for (int i = 0; i < 2; i++) begin
         cmd(soch_pkg::OP_IMP, i, 1'b0);
         qry(soch_pkg::OP_IMP_Q, i);
      end
   endtask
   task automatic t_video();
      cmd(soch_pkg::OP_MODE, 6, 1'b0);
      for (int f = 3; f >= 0; f--) begin
         cmd(soch_pkg::OP_VFMT, f, 1'b0);
         qry(soch_pkg::OP_VFMT_Q, f);
      end
      cmd(soch_pkg::OP_VFMT, 2, 1'b0);
      cmd(soch_pkg::OP_VMARK, 25, 1'b0);
      qry(soch_pkg::OP_VMARK_Q, 25);
      cmd(soch_pkg::OP_OUT, -70, 1'b0);
      check("level", 70, settings.level);
      check("invert", 1, settings.invert);
      cmd(soch_pkg::OP_MODE, 6, 1'b0);
      check("level", 100, settings.level);
      check("line", 10, settings.video_line_marker);
      check("format", 0, settings.video_format_select);
      qry(soch_pkg::OP_MODE_Q, 6);
   endtask
   task automatic t_range();
      cmd(soch_pkg::OP_MODE, 1, 1'b0);
      cmd(soch_pkg::OP_RANGE, 0, 1'b1);
      cmd(soch_pkg::OP_MODE, 7, 1'b0);
      check("width", 100, settings.pulse_width);
      check("period", 1000, settings.pulse_period);
      check("prng", 0, settings.prng);
      for (int r = 0; r < 6; r++) begin
         cmd(soch_pkg::OP_RANGE, r, 1'b0);
         check("prng", r, settings.prng);
      end
      cmd(soch_pkg::OP_RANGE, 6, 1'b1);
      check("prng", 5, settings.prng);
      cmd(soch_pkg::OP_MODE, 8, 1'b0);
      for (int r = 0; r < 3; r++) begin
         cmd(soch_pkg::OP_RANGE, r, 1'b0);
         check("zrng", r, settings.zrng);
      end
      cmd(soch_pkg::OP_RANGE, 3, 1'b1);
      cmd(soch_pkg::OP_MODE, 9, 1'b0);
      check("orng", 0, settings.orng);
      check("level", 5000, settings.level);
      cmd(soch_pkg::OP_RANGE, 1, 1'b0);
      check("orng", 1, settings.orng);
   endtask
   task automatic t_edge();
      cmd(soch_pkg::OP_MODE, 2, 1'b0);
      cmd(soch_pkg::OP_DPULSE, 5, 1'b0);
      qry(soch_pkg::OP_DPULSE_Q, 1);
      cmd(soch_pkg::OP_DPULSE, 0, 1'b0);
      qry(soch_pkg::OP_DPULSE_Q, 0);
      for (int w = 0; w < 4; w++) begin
         cmd(soch_pkg::OP_WAVE, w, 1'b0);
         qry(soch_pkg::OP_WAVE_Q, w);
      end
   endtask
   task automatic t_overload();
      cmd(soch_pkg::OP_TLIM, 0, 1'b1);
      cmd(soch_pkg::OP_TLIM, 61, 1'b1);
      cmd(soch_pkg::OP_TLIM, 60, 1'b0);
      qry(soch_pkg::OP_TLIM_Q, 60);
      cmd(soch_pkg::OP_TLIMD, 3, 1'b0);
      qry(soch_pkg::OP_TLIMD_Q, 3);
      cmd(soch_pkg::OP_MODE, 9, 1'b0);
      qry(soch_pkg::OP_TLIM_Q, 3);
      cmd(soch_pkg::OP_OPER, 0, 1'b0);
      repeat (3 * SEC - 6) @(negedge clk_sys);
      check("operate", 1, operate);
      repeat (10) @(negedge clk_sys);
      check("operate", 0, operate);
      qry(soch_pkg::OP_TRIP_Q, 0);
      cmd(soch_pkg::OP_OPER, 0, 1'b0);
      repeat (SEC + 5) @(posedge clk_sys);
      prot_trip <= 1'b1;
      repeat (6) @(negedge clk_sys);
      check("operate", 0, operate);
      qry(soch_pkg::OP_TRIP_Q, 2);
      @(posedge clk_sys);
      prot_trip <= 1'b0;
      cmd(soch_pkg::OP_OPER, 0, 1'b0);
      check("operate", 1, operate);
      cmd(soch_pkg::OP_STBY, 0, 1'b0);
      check("operate", 0, operate);
      cmd(soch_pkg::OP_MODE, 1, 1'b0);
      qry(soch_pkg::OP_TRIP_Q, 0);
   endtask
   task automatic meas(input logic cap, input int v, input int e,
                       input int tag);
      int s;
      int n;
      @(posedge clk_sys);
      m_cap <= cap;
      m_val <= v;
      s = n_starts;
      send(soch_pkg::OP_MEAS_TRG, 0);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (rsp_valid !== 1'b1 && n < 40);
      check("starts", s + 1, n_starts);
      check("tag", tag, rsp.tag);
      check("value", e, rsp.value);
      s = n_starts;
      qry(soch_pkg::OP_VAL_Q, e);
      check("tag", tag, rsp.tag);
      check("starts", s, n_starts);
   endtask
   task automatic t_meas();
      cmd(soch_pkg::OP_MEAS_TRG, 0, 1'b1);
      cmd(soch_pkg::OP_MODE, 8, 1'b0);
      send(soch_pkg::OP_VAL_Q, 0);
      @(negedge clk_sys);
      check("tag", soch_pkg::TAG_NONE, rsp.tag);
      meas(1'b0, 1000, 1000, soch_pkg::TAG_OHM);
      meas(1'b1, 47, 47, soch_pkg::TAG_FARAD);
      cmd(soch_pkg::OP_ZERO, 1, 1'b0);
      check("zeroing", 1, settings.capacitance_zeroing);
      // Offset of 47 now taken off every capacitance result
      meas(1'b1, 50, 3, soch_pkg::TAG_FARAD);
      cmd(soch_pkg::OP_ZERO, 0, 1'b0);
      check("zeroing", 0, settings.capacitance_zeroing);
   endtask

   initial begin
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = soch_pkg::OP_MODE;
      cmd_arg = '0;
      prot_trip = 1'b0;
      m_cap = 1'b0;
      m_val = '0;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (2) @(negedge clk_sys);
      check("ready", 1, cmd_ready);
      check("mode", 0, settings.mode);
      qry(soch_pkg::OP_TLIM_Q, 10);
      t_modes();
      t_trigger_output_divider_imp();
      t_video();
      t_range();
      t_edge();
      t_overload();
      t_meas();
      report_and_stop();
   end
endmodule
